// *** hdl/fchd_core.sv ***
// Full-closed hybrid deviation core: feedback totals, scaling, excess check, APB registers.
// Assumes an APB master on i_clk_sys, and serial scale words already on this clock.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "fchd_params.svh"
module fchd_core #(
  parameter logic [31:0] COUNTS_PER_REV = `FCHD_COUNTS_PER_REV
) (
  input wire logic i_clk_sys, // System clock, 200 MHz
  input wire logic i_rst, // Asynchronous reset, active high
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB direction
  input wire fchd_pkg::fchd_addr_type i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error on unmapped address
  input wire logic i_enc_a, // Motor encoder phase A
  input wire logic i_enc_b, // Motor encoder phase B
  input wire logic i_scl_a, // External scale phase A
  input wire logic i_scl_b, // External scale phase B
  input wire logic i_scl_word_valid, // Serial scale word strobe
  input wire logic [31:0] i_scl_word, // Serial scale position or delta
  output logic o_deviation_excess_error, // Latched excess error
  output logic o_irq // Level interrupt
);
  import fchd_pkg::*;
  function automatic logic [31:0] fchd_abs(input fchd_pos_type v);
    fchd_abs = v[31] ? 32'(-v) : 32'(v);
  endfunction : fchd_abs
  fchd_step_if enc_step ();
  fchd_step_if scl_step ();
  fchd_scale_type type_reg;
  logic invert_reg;
  logic [20:0] num_reg;
  logic [20:0] den_reg;
  logic [27:0] limit_reg;
  logic [6:0] revs_reg;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [1:0] mask_reg;
  logic irq_reg;
  logic err_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  fchd_pos_type enc_total_reg;
  fchd_pos_type scl_total_reg;
  fchd_pos_type offset_reg;
  fchd_pos_type deviation_reg;
  fchd_pos_type abs_last_reg;
  logic abs_seen_reg;
  fchd_pos_type scaled;
  fchd_pos_type raw;
  fchd_pos_type scl_delta;
  logic scl_delta_valid;
  logic [31:0] rev_pos_reg;
  logic [6:0] rev_cnt_reg;
  logic clear_pulse_reg;
  logic excess;
  logic wr;
  logic [1:0] w1c;
  logic [31:0] rd_mux;
  logic rd_err;
  fchd_quad_dec u_enc_dec (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_a(i_enc_a),
    .i_b(i_enc_b),
    .step(enc_step)
  );
  fchd_quad_dec u_scl_dec (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_a(i_scl_a),
    .i_b(i_scl_b),
    .step(scl_step)
  );
  fchd_scaler u_scaler (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_delta_valid(scl_delta_valid),
    .i_delta(scl_delta),
    .i_num(num_reg),
    .i_den(den_reg),
    .o_scaled(scaled),
    .o_done()
  );
  // Scale source selection and direction reversal
  always_comb
  begin
    scl_delta = '0;
    scl_delta_valid = 1'b0;
    unique case (type_reg)
      FCHD_SCALE_AB:
      begin
        scl_delta_valid = scl_step.valid;
        scl_delta = scl_step.up ? 32'sh00000001 : -32'sh00000001;
      end
      FCHD_SCALE_SERIAL_INC:
      begin
        scl_delta_valid = i_scl_word_valid;
        scl_delta = i_scl_word;
      end
      FCHD_SCALE_SERIAL_ABS:
      begin
        scl_delta_valid = i_scl_word_valid && abs_seen_reg;
        scl_delta = i_scl_word - abs_last_reg;
      end
    endcase
    if (invert_reg)
      scl_delta = -scl_delta;
  end
  // First absolute word after reset or any write to CTRL only sets the reference
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      abs_last_reg <= '0;
      abs_seen_reg <= 1'b0;
    end
    else if (wr && i_paddr == `FCHD_OFS_CTRL)
      abs_seen_reg <= 1'b0;
    else if (i_scl_word_valid && type_reg == FCHD_SCALE_SERIAL_ABS)
    begin
      abs_last_reg <= i_scl_word;
      abs_seen_reg <= 1'b1;
    end
  end
  // Feedback pulse sums
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      enc_total_reg <= '0;
      scl_total_reg <= '0;
    end
    else
    begin
      if (enc_step.valid)
        enc_total_reg <= enc_step.up ? enc_total_reg + 32'sh1 : enc_total_reg - 32'sh1;
      if (scl_delta_valid)
        scl_total_reg <= scl_total_reg + scl_delta;
    end
  end
  // Revolution counting on travel in either direction
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      rev_pos_reg <= 32'h00000000;
      rev_cnt_reg <= 7'h00;
      clear_pulse_reg <= 1'b0;
    end
    else
    begin
      clear_pulse_reg <= 1'b0;
      if (revs_reg == 7'h00)
      begin
        rev_pos_reg <= 32'h00000000;
        rev_cnt_reg <= 7'h00;
      end
      else if (enc_step.valid)
      begin
        if (rev_pos_reg >= COUNTS_PER_REV - 32'h00000001)
        begin
          rev_pos_reg <= 32'h00000000;
          if (rev_cnt_reg + 7'h01 >= revs_reg)
          begin
            rev_cnt_reg <= 7'h00;
            clear_pulse_reg <= 1'b1;
          end
          else
            rev_cnt_reg <= rev_cnt_reg + 7'h01;
        end
        else
          rev_pos_reg <= rev_pos_reg + 32'h00000001;
      end
    end
  end
  assign raw = enc_total_reg - scaled;
  // Hybrid deviation held against an offset taken at each clear
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      offset_reg <= '0;
      deviation_reg <= '0;
    end
    else if (clear_pulse_reg)
    begin
      offset_reg <= raw;
      deviation_reg <= '0;
    end
    else
      deviation_reg <= raw - offset_reg;
  end
  assign excess = fchd_abs(deviation_reg) > {4'h0, limit_reg};
  assign wr = i_psel && i_penable && pready_reg && i_pwrite;
  assign w1c = (wr && i_paddr == `FCHD_OFS_INT_STATUS) ? i_pwdata[1:0] : 2'h0;
  // Error stays until software clears it; a live excess wins over the clear
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      err_reg <= 1'b0;
    else if (excess)
      err_reg <= 1'b1;
    else if (w1c[`FCHD_INT_EXCESS_BIT])
      err_reg <= 1'b0;
  end
  always_comb
  begin
    status_next = status_reg & ~w1c;
    status_next[`FCHD_INT_EXCESS_BIT] = status_next[`FCHD_INT_EXCESS_BIT] | excess;
    status_next[`FCHD_INT_CLEAR_BIT] = status_next[`FCHD_INT_CLEAR_BIT] | clear_pulse_reg;
  end
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      status_reg <= 2'h0;
      irq_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      irq_reg <= |(status_next & mask_reg);
    end
  end
  // Configuration writes, out-of-range values clamped or refused
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      type_reg <= fchd_scale_type'(`FCHD_RST_TYPE);
      invert_reg <= 1'b0;
      num_reg <= `FCHD_RST_NUM;
      den_reg <= `FCHD_RST_DEN;
      limit_reg <= `FCHD_RST_LIMIT;
      revs_reg <= `FCHD_RST_REVS;
      mask_reg <= `FCHD_RST_MASK;
    end
    else if (wr)
    begin
      unique case (i_paddr)
        `FCHD_OFS_CTRL:
        begin
          if (i_pwdata[`FCHD_CTRL_TYPE_LSB+1:`FCHD_CTRL_TYPE_LSB] != 2'h3)
            type_reg <= fchd_scale_type'(i_pwdata[`FCHD_CTRL_TYPE_LSB+1:`FCHD_CTRL_TYPE_LSB]);
          invert_reg <= i_pwdata[`FCHD_CTRL_INV_BIT];
        end
        `FCHD_OFS_NUM:
          num_reg <= (i_pwdata > 32'(`FCHD_NUM_MAX)) ? `FCHD_NUM_MAX : i_pwdata[20:0];
        `FCHD_OFS_DEN:
          if (i_pwdata != 32'h00000000)
            den_reg <= (i_pwdata > 32'(`FCHD_DEN_MAX)) ? `FCHD_DEN_MAX : i_pwdata[20:0];
        `FCHD_OFS_LIMIT:
          if (i_pwdata != 32'h00000000)
            limit_reg <= (i_pwdata > 32'(`FCHD_LIMIT_MAX)) ? `FCHD_LIMIT_MAX : i_pwdata[27:0];
        `FCHD_OFS_REVS:
          revs_reg <= (i_pwdata > 32'(`FCHD_REVS_MAX)) ? `FCHD_REVS_MAX : i_pwdata[6:0];
        `FCHD_OFS_INT_MASK:
          mask_reg <= i_pwdata[1:0];
        default:
          mask_reg <= mask_reg;
      endcase
    end
  end
  always_comb
  begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    unique case (i_paddr)
      `FCHD_OFS_CTRL: rd_mux = {29'h0, invert_reg, type_reg};
      `FCHD_OFS_NUM: rd_mux = {11'h0, num_reg};
      `FCHD_OFS_DEN: rd_mux = {11'h0, den_reg};
      `FCHD_OFS_LIMIT: rd_mux = {4'h0, limit_reg};
      `FCHD_OFS_REVS: rd_mux = {25'h0, revs_reg};
      `FCHD_OFS_ENC_TOTAL: rd_mux = enc_total_reg;
      `FCHD_OFS_SCL_TOTAL: rd_mux = scl_total_reg;
      `FCHD_OFS_DEVIATION: rd_mux = deviation_reg;
      `FCHD_OFS_INT_STATUS: rd_mux = {30'h0, status_reg};
      `FCHD_OFS_INT_MASK: rd_mux = {30'h0, mask_reg};
      default: rd_err = 1'b1;
    endcase
  end
  // No wait state: answer is prepared in the setup cycle
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end
    else if (i_psel && !i_penable)
    begin
      pready_reg <= 1'b1;
      prdata_reg <= i_pwrite ? 32'h00000000 : rd_mux;
      pslverr_reg <= rd_err;
    end
    else
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end
  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_deviation_excess_error = err_reg;
  assign o_irq = irq_reg;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  chk_dev_tracks_raw: assert property (!clear_pulse_reg |=> deviation_reg == $past(raw) - $past(offset_reg))
    else $error("deviation not encoder minus scaled scale");
  chk_excess_sets_err: assert property (excess |=> err_reg && status_reg[0])
    else $error("excess did not latch error");
  chk_limit_range: assert property (limit_reg >= `FCHD_LIMIT_MIN && limit_reg <= `FCHD_LIMIT_MAX)
    else $error("limit out of range");
  chk_clear_zeroes: assert property (clear_pulse_reg |=> deviation_reg == 32'sh0 && status_reg[1])
    else $error("deviation not cleared");
  chk_type_legal: assert property (type_reg != fchd_scale_type'(2'h3))
    else $error("illegal scale type");
  chk_invert_ab: assert property ((type_reg == FCHD_SCALE_AB && scl_step.valid) |=>
    scl_total_reg == $past(scl_total_reg) + (($past(scl_step.up) ^ $past(invert_reg)) ?
    32'sh1 : -32'sh1))
    else $error("scale direction wrong");
  chk_num_range: assert property (num_reg <= `FCHD_NUM_MAX)
    else $error("numerator out of range");
  chk_den_range: assert property (den_reg >= `FCHD_DEN_MIN && den_reg <= `FCHD_DEN_MAX)
    else $error("denominator out of range");
  chk_enc_total: assert property (enc_step.valid && enc_step.up |=>
    enc_total_reg == $past(enc_total_reg) + 32'sh1)
    else $error("encoder total not counted");
  chk_err_latched: assert property ((err_reg && !w1c[0]) |=> err_reg)
    else $error("error dropped without clear");
  chk_irq_level: assert property (o_irq == |(status_reg & $past(mask_reg)))
    else $error("irq does not follow masked status");
  cov_excess: cover property (!err_reg ##1 err_reg);
  cov_clear: cover property (clear_pulse_reg);
  cov_serial_abs: cover property (type_reg == FCHD_SCALE_SERIAL_ABS && scl_delta_valid);
  cov_irq: cover property (o_irq ##1 !o_irq);
endmodule : fchd_core

// *** hdl/fchd_params.svh ***
// Constants of the full-closed hybrid deviation block: offsets, fields, reset values.
// Assumes inclusion by bare name from the design modules and the bench.
`ifndef FCHD_PARAMS_SVH
`define FCHD_PARAMS_SVH
`define FCHD_OFS_CTRL 8'h00
`define FCHD_OFS_NUM 8'h04
`define FCHD_OFS_DEN 8'h08
`define FCHD_OFS_LIMIT 8'h0C
`define FCHD_OFS_REVS 8'h10
`define FCHD_OFS_ENC_TOTAL 8'h14
`define FCHD_OFS_SCL_TOTAL 8'h18
`define FCHD_OFS_DEVIATION 8'h1C
`define FCHD_OFS_INT_STATUS 8'h20
`define FCHD_OFS_INT_MASK 8'h24
`define FCHD_CTRL_TYPE_LSB 0
`define FCHD_CTRL_INV_BIT 2
`define FCHD_INT_EXCESS_BIT 0
`define FCHD_INT_CLEAR_BIT 1
`define FCHD_NUM_MAX 21'h100000
`define FCHD_DEN_MIN 21'h000001
`define FCHD_DEN_MAX 21'h100000
`define FCHD_LIMIT_MIN 28'h0000001
`define FCHD_LIMIT_MAX 28'h8000000
`define FCHD_REVS_MAX 7'h64
`define FCHD_RST_TYPE 2'h0
`define FCHD_RST_NUM 21'h000001
`define FCHD_RST_DEN 21'h000001
`define FCHD_RST_LIMIT 28'h0000400
`define FCHD_RST_REVS 7'h00
`define FCHD_RST_MASK 2'h0
`define FCHD_COUNTS_PER_REV 32'h00002710
`define FCHD_DIV_STEPS 6'h38
`endif

// *** hdl/fchd_pkg.sv ***
// Types shared by the full-closed hybrid deviation block.
// Assumes fchd_params.svh sits on the include path.
package fchd_pkg;
  typedef enum logic [1:0] {
    FCHD_SCALE_AB = 2'b00,
    FCHD_SCALE_SERIAL_INC = 2'b01,
    FCHD_SCALE_SERIAL_ABS = 2'b10
  } fchd_scale_type;
  typedef enum logic {
    FCHD_DIV_IDLE = 1'b0,
    FCHD_DIV_RUN = 1'b1
  } fchd_div_state_type;
  typedef logic [7:0] fchd_addr_type;
  typedef logic signed [31:0] fchd_pos_type;
endpackage : fchd_pkg

// *** hdl/fchd_quad_dec.sv ***
// Quadrature A/B decoder with three-flop pin synchronisers.
// Assumes asynchronous pins and i_clk_sys far faster than the edge rate.
`timescale 1ns/1ps
module fchd_quad_dec (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Asynchronous reset, active high
  input wire logic i_a, // Phase A pin
  input wire logic i_b, // Phase B pin
  fchd_step_if.src step // One-cycle count steps
);
  import fchd_pkg::*;
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] s3_reg;
  logic [1:0] ab_reg;
  logic valid_reg;
  logic up_reg;
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
      s3_reg <= 2'h0;
    end
    else
    begin
      s1_reg <= {i_a, i_b};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  // Accept a level only once the second and third stages agree
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      ab_reg <= 2'h0;
      valid_reg <= 1'b0;
      up_reg <= 1'b0;
    end
    else
    begin
      valid_reg <= 1'b0;
      if (s2_reg == s3_reg && s2_reg != ab_reg)
      begin
        ab_reg <= s2_reg;
        // Both phases flipping at once is a lost state: no count
        valid_reg <= (s2_reg ^ ab_reg) != 2'h3;
        up_reg <= ab_reg[1] ^ s2_reg[0];
      end
    end
  end
  assign step.valid = valid_reg;
  assign step.up = up_reg;
endmodule : fchd_quad_dec

// *** hdl/fchd_scaler.sv ***
// Scales scale counts into encoder units by numerator over denominator.
// Assumes the denominator is never zero; the quotient trails the input by a divide.
`timescale 1ns/1ps
`include "fchd_params.svh"
module fchd_scaler #(
  parameter int ACC_W = 56
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Asynchronous reset, active high
  input wire logic i_delta_valid, // Scale delta present
  input wire fchd_pkg::fchd_pos_type i_delta, // Signed scale delta
  input wire logic [20:0] i_num, // Ratio numerator
  input wire logic [20:0] i_den, // Ratio denominator
  output fchd_pkg::fchd_pos_type o_scaled, // Scaled scale position
  output logic o_done // Pulse when o_scaled updates
);
  import fchd_pkg::*;
  fchd_div_state_type state_reg;
  logic signed [ACC_W-1:0] acc_reg;
  logic signed [53:0] prod;
  logic [ACC_W-1:0] dvd_reg;
  logic [ACC_W-1:0] quo_reg;
  logic [21:0] rem_reg;
  logic [21:0] rem_sh;
  logic [20:0] den_reg;
  logic neg_reg;
  logic [5:0] cnt_reg;
  fchd_pos_type scaled_reg;
  logic done_reg;
  assign prod = i_delta * $signed({1'b0, i_num});
  assign rem_sh = {rem_reg[20:0], dvd_reg[ACC_W-1]};
  // Product sum kept exact so no remainder is ever lost
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      acc_reg <= '0;
    else if (i_delta_valid)
      acc_reg <= acc_reg + ACC_W'(prod);
  end
  // Restoring divider runs continuously on snapshots of the sum
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= FCHD_DIV_IDLE;
      dvd_reg <= '0;
      quo_reg <= '0;
      rem_reg <= 22'h000000;
      den_reg <= `FCHD_RST_DEN;
      neg_reg <= 1'b0;
      cnt_reg <= 6'h00;
      scaled_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      unique case (state_reg)
        FCHD_DIV_IDLE:
        begin
          neg_reg <= acc_reg[ACC_W-1];
          dvd_reg <= acc_reg[ACC_W-1] ? ACC_W'(-acc_reg) : acc_reg;
          den_reg <= i_den;
          rem_reg <= 22'h000000;
          cnt_reg <= 6'h00;
          state_reg <= FCHD_DIV_RUN;
        end
        FCHD_DIV_RUN:
        begin
          dvd_reg <= {dvd_reg[ACC_W-2:0], 1'b0};
          if (rem_sh >= {1'b0, den_reg})
          begin
            rem_reg <= rem_sh - {1'b0, den_reg};
            quo_reg <= {quo_reg[ACC_W-2:0], 1'b1};
          end
          else
          begin
            rem_reg <= rem_sh;
            quo_reg <= {quo_reg[ACC_W-2:0], 1'b0};
          end
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == `FCHD_DIV_STEPS - 6'h01)
            state_reg <= FCHD_DIV_IDLE;
        end
      endcase
      if (state_reg == FCHD_DIV_IDLE && cnt_reg == `FCHD_DIV_STEPS)
      begin
        scaled_reg <= neg_reg ? -quo_reg[31:0] : quo_reg[31:0];
        done_reg <= 1'b1;
      end
    end
  end
  assign o_scaled = scaled_reg;
  assign o_done = done_reg;
  chk_div_finishes: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_reg == FCHD_DIV_RUN && cnt_reg == 6'h00) |-> ##[56:57] done_reg)
    else $error("divider did not finish in time");
endmodule : fchd_scaler

// *** hdl/fchd_step_if.sv ***
// Carrier for single count steps from a quadrature decoder to the core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface fchd_step_if;
  logic valid;
  logic up;
  modport src (output valid, output up);
  modport dst (input valid, input up);
endinterface : fchd_step_if

// *** testbench/fchd_feed_model.sv ***
// Partner model: motor encoder and external scale feeding the deviation core.
// Assumes the bench calls one task at a time for each feedback source.
`timescale 1ns/1ps
module fchd_feed_model (
  input wire logic i_clk_sys, // System clock
  output logic o_enc_a, // Encoder phase A
  output logic o_enc_b, // Encoder phase B
  output logic o_scl_a, // Scale phase A
  output logic o_scl_b, // Scale phase B
  output logic o_word_valid, // Serial word strobe
  output logic [31:0] o_word // Serial word
);
  logic [1:0] gray [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  int idx [2] = '{0, 0};
  initial
  begin
    {o_enc_a, o_enc_b} = 2'b00;
    {o_scl_a, o_scl_b} = 2'b00;
    o_word_valid = 1'b0;
    o_word = 32'h00000000;
  end
  // Steps in the source's own units, held 8 clocks to clear the pin synchroniser
  task automatic move(input int src, input int n);
    repeat (n < 0 ? -n : n)
    begin
      idx[src] += (n < 0) ? -1 : 1;
      @(posedge i_clk_sys);
      if (src == 0)
        {o_enc_a, o_enc_b} <= gray[idx[0] & 3];
      else
        {o_scl_a, o_scl_b} <= gray[idx[1] & 3];
      repeat (7) @(posedge i_clk_sys);
    end
  endtask : move
  task automatic send_word(input logic [31:0] w);
    @(posedge i_clk_sys);
    o_word_valid <= 1'b1;
    o_word <= w;
    @(posedge i_clk_sys);
    o_word_valid <= 1'b0;
    o_word <= ~w; // Idle word lines carry no stale value
  endtask : send_word
endmodule : fchd_feed_model

// *** testbench/full_closed_hybrid_deviation_test.sv ***
// Self-checking bench for the full-closed hybrid deviation core.
// Assumes fchd_params.svh on the include path and the feed model beside it.
`timescale 1ns/1ps
`include "fchd_params.svh"
module full_closed_hybrid_deviation_test;
  logic clk, rst, psel, penable, pwrite, last_err, wv, enc_a, enc_b, scl_a, scl_b, err, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, word, q;
  logic pready, pslverr;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int e_enc = 0;
  int e_scl = 0;
  int acc = 0;
  int num = 3;
  int den = 2;
  logic [7:0] ca [15] = '{`FCHD_OFS_NUM, `FCHD_OFS_NUM, `FCHD_OFS_DEN, `FCHD_OFS_DEN,
    `FCHD_OFS_LIMIT, `FCHD_OFS_LIMIT, `FCHD_OFS_REVS, `FCHD_OFS_CTRL, `FCHD_OFS_CTRL,
    `FCHD_OFS_NUM, `FCHD_OFS_DEN, `FCHD_OFS_LIMIT, `FCHD_OFS_REVS, `FCHD_OFS_CTRL,
    `FCHD_OFS_INT_MASK};
  logic [31:0] cw [15] = '{32'h1FFFFF, 32'h0, 32'h0, 32'h200000, 32'h0, 32'hFFFFFFF,
    32'hC8, 32'h3, 32'h7, 32'h3, 32'h2, 32'h400, 32'h0, 32'h0, 32'h0};
  logic [31:0] ce [15] = '{32'h100000, 32'h0, 32'h1, 32'h100000, 32'h400, 32'h8000000,
    32'h64, 32'h0, 32'h4, 32'h3, 32'h2, 32'h400, 32'h0, 32'h0, 32'h0};
  fchd_core #(.COUNTS_PER_REV(32'h00000008)) DUT (.i_clk_sys(clk), .i_rst(rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_enc_a(enc_a), .i_enc_b(enc_b), .i_scl_a(scl_a), .i_scl_b(scl_b),
    .i_scl_word_valid(wv), .i_scl_word(word), .o_deviation_excess_error(err), .o_irq(irq));
  fchd_feed_model u_feed (.i_clk_sys(clk), .o_enc_a(enc_a), .o_enc_b(enc_b),
    .o_scl_a(scl_a), .o_scl_b(scl_b), .o_word_valid(wv), .o_word(word));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the slave; only the bench timeout ends a hang
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd_chk
  task automatic settle();
    repeat (150) @(posedge clk);
  endtask : settle
  task automatic mv_scl(input int n, input int inv);
    u_feed.move(1, n);
    e_scl += inv ? -n : n;
    acc += (inv ? -n : n) * num;
  endtask : mv_scl
  task automatic check_pos();
    settle();
    rd_chk(`FCHD_OFS_ENC_TOTAL, e_enc);
    rd_chk(`FCHD_OFS_SCL_TOTAL, e_scl);
    rd_chk(`FCHD_OFS_DEVIATION, e_enc - acc / den);
  endtask : check_pos
  task automatic t_regs();
    check_pos();
    rd_chk(`FCHD_OFS_INT_STATUS, 32'h0);
    apb(1'b1, 8'h28, 32'h5);
    chk(last_err, 1'b1);
    apb(1'b0, 8'h28, 32'h0);
    chk(last_err, 1'b1);
    chk(q, 32'h0);
    for (int i = 0; i < 15; i++)
    begin
      wr(ca[i], cw[i]);
      rd_chk(ca[i], ce[i]);
    end
    $display("done: registers");
  endtask : t_regs
  task automatic t_motion();
    u_feed.move(0, 8);
    e_enc += 8;
    mv_scl(4, 0);
    check_pos();
    mv_scl(-5, 0);
    check_pos();
    wr(`FCHD_OFS_CTRL, 32'h4);
    mv_scl(2, 1);
    check_pos();
    wr(`FCHD_OFS_CTRL, 32'h1);
    u_feed.send_word(32'h5);
    e_scl += 5;
    acc += 5 * num;
    check_pos();
    wr(`FCHD_OFS_CTRL, 32'h2);
    u_feed.send_word(32'h100);
    u_feed.send_word(32'h105);
    e_scl += 5;
    acc += 5 * num;
    check_pos();
    wr(`FCHD_OFS_CTRL, 32'h0);
    $display("done: motion");
  endtask : t_motion
  task automatic t_excess();
    wr(`FCHD_OFS_LIMIT, 32'h4);
    wr(`FCHD_OFS_INT_MASK, 32'h1);
    settle();
    chk({err, irq}, 2'b00);
    u_feed.move(0, 8);
    e_enc += 8;
    check_pos();
    chk({err, irq}, 2'b11);
    rd_chk(`FCHD_OFS_INT_STATUS, 32'h1);
    wr(`FCHD_OFS_INT_STATUS, 32'h1);
    wr(`FCHD_OFS_INT_MASK, 32'h0);
    repeat (3) @(posedge clk);
    chk({err, irq}, 2'b10);
    wr(`FCHD_OFS_INT_MASK, 32'h3);
    wr(`FCHD_OFS_REVS, 32'h1);
    u_feed.move(0, 8);
    e_enc += 8;
    settle();
    rd_chk(`FCHD_OFS_ENC_TOTAL, e_enc);
    rd_chk(`FCHD_OFS_DEVIATION, 32'h0);
    rd_chk(`FCHD_OFS_INT_STATUS, 32'h3);
    wr(`FCHD_OFS_LIMIT, 32'h8000000);
    wr(`FCHD_OFS_INT_STATUS, 32'h3);
    repeat (3) @(posedge clk);
    chk({err, irq}, 2'b00);
    $display("done: excess and clear");
  endtask : t_excess
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_motion();
    t_excess();
    wrap_up();
  end
endmodule : full_closed_hybrid_deviation_test
